// ==== inc/adcsc_cfg.svh ====
// Constants for the converter sequencer and calibration control block.
// Assumes one 20 MHz clock; included by its bare name.
//
// Functional notes
// - Eight instructions of 48 bits, each three separately accessible 16-bit sections.
// - Sixteen-bit bus decodes instructions at upper address lines 0000 to 0111.
// - Eight-bit bus decodes five address lines 00000 to 01111, byte each.
// - Instruction entries are read and written in any order.
// - Two-bit section pointer picks the section; 00 is channel and timing.
// - Section two holds limit one with sign and direction; three holds limit two.
// - A status bit shows whether the sequencer is running.
// - Diagnostic bit routes references and ground onto the sample-and-hold.
// - Result FIFO keeps 32 results without host help, readable any time.
// - Interrupt on FIFO full or on a programmed result count.
// - Offset-only calibration measures offset once for the coefficient.
// - Full calibration averages eight offset measurements into the register.
// - Each ladder capacitor compared eight times; average gives one of 13 coefficients.
// - A state machine steps calibration from a 16 by 8-bit pattern ROM.
// - Twelve-bit mode applies offset and 13 linearity terms; 8-bit only offset.
// - Modes are corrected 12-bit, offset-corrected 8-bit and 8-bit limit comparison.
// - Comparison checks two limits, above or below each as programmed.
// - Any channel single-ended to ground, or any two paired differentially.
// - Acquisition programmable from 1.5 us to 6.0 us.
// - An 8-bit conversion takes under half the 12-bit conversion time.
// - Bus width select high gives 8-bit transfers, upper lines released.
`ifndef ADCSC_CFG_SVH
`define ADCSC_CFG_SVH
`define ADCSC_CLK_MHZ 20
`define ADCSC_ACQ_MIN_NS 1500
`define ADCSC_ACQ_MAX_NS 6500
`define ADCSC_ACQ_MIN_CYC ((`ADCSC_ACQ_MIN_NS*`ADCSC_CLK_MHZ+999)/1000)
`define ADCSC_ACQ_MAX_CYC ((`ADCSC_ACQ_MAX_NS*`ADCSC_CLK_MHZ)/1000)
`define ADCSC_ACQ_STEP_CYC ((`ADCSC_ACQ_MAX_CYC-`ADCSC_ACQ_MIN_CYC)/15)
`define ADCSC_CONV12_CYC 44
`define ADCSC_CONV8_CYC 20
`define ADCSC_CAL_REPS 8
`define ADCSC_LIN_COEFS 13
`define ADCSC_FIFO_DEPTH 32
`define ADCSC_I_LOOP 0
`define ADCSC_I_PAUSE 1
`define ADCSC_I_POS_LSB 2
`define ADCSC_I_NEG_LSB 5
`define ADCSC_I_RES8 10
`define ADCSC_I_WDOG 11
`define ADCSC_I_ACQ_LSB 12
`define ADCSC_L_SIGN 8
`define ADCSC_L_DIR 9
`define ADCSC_ROM_OFFSET 8'h80
`define ADCSC_ROM_CAP 4'h4
`endif

// ==== inc/adcsc_pkg.sv ====
// Types for the converter sequencer and calibration control block.
// Assumes adcsc_cfg.svh for all numeric constants.
package adcsc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_ACQ = 3'b010,
    ST_CONV = 3'b011,
    ST_STORE = 3'b100,
    ST_CAL_MEAS = 3'b101,
    ST_CAL_WAIT = 3'b110
  } adcsc_state_t;
endpackage

// ==== hdl/adcsc_top.sv ====
// Sequencer, instruction memory, calibration and result FIFO of the converter.
// Assumes the analog core and config register sit on mclk; bus pins do not.
`timescale 1ns/1ns
`default_nettype none
`include "adcsc_cfg.svh"

module adcsc_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Async reset
  input wire logic [W-1:0] in_data, // Write word
  input wire logic in_valid, // Write request
  output logic in_ready, // Room left
  output logic [W-1:0] out_data, // Oldest word
  output logic out_valid, // Not empty
  input wire logic out_ready, // Reader takes word
  output logic [$clog2(D+1)-1:0] count // Words held
);
  localparam int AW = $clog2(D);
  initial begin
    if (D < 2 || (1 << AW) != D) $error("Depth must be a power of two");
  end
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [$clog2(D+1)-1:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = (cnt_reg != D[$clog2(D+1)-1:0]);
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rp_reg];
  assign count = cnt_reg;
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
  // Oldest first: read pointer trails write pointer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_reg + AW'(push);
      rp_reg <= rp_reg + AW'(pop);
      cnt_reg <= cnt_reg + ($clog2(D+1))'(push) - ($clog2(D+1))'(pop);
    end
  end
endmodule // adcsc_fifo

module adcsc_top #(
  parameter int FIFO_DEPTH = `ADCSC_FIFO_DEPTH
) (
  input wire logic mclk, // 20 MHz clock
  input wire logic rst_n, // Async reset
  input wire logic cs_n, // Chip select pin
  input wire logic rd_n, // Read strobe pin
  input wire logic wr_n, // Write strobe pin
  input wire logic ale, // Address latch enable pin
  input wire logic [4:0] addr, // Address pins
  input wire logic bus_width_select, // High for 8-bit bus
  input wire logic [15:0] data_in, // Data pins in
  output logic [15:0] data_out, // Data pins out
  output logic [15:0] data_oe, // Data pin drive enables
  input wire logic cfg_start, // Start bit
  input wire logic cfg_soft_reset, // Soft reset pulse
  input wire logic [1:0] cfg_ram_pointer, // Section pointer
  input wire logic cfg_diag, // Diagnostic routing bit
  input wire logic cal_offset_req, // Offset calibration pulse
  input wire logic cal_full_req, // Full calibration pulse
  input wire logic [5:0] fifo_int_count, // Result count for interrupt
  input wire logic fifo_int_clear, // Clears fill interrupt
  output logic seq_running, // Sequencer status bit
  output logic pause_event, // Pause reached, clears start
  output logic [2:0] mux_pos, // Non-inverting channel
  output logic [2:0] mux_neg, // Inverting channel, 0 is ground
  output logic mux_diag, // References onto sample-and-hold
  output logic sh_acquire, // Sample-and-hold tracking
  output logic sar_start, // Conversion start pulse
  output logic sar_res8, // Short conversion
  output logic [7:0] cal_pattern, // Calibration step pattern
  input wire logic [12:0] adc_raw, // Raw core result
  output logic cal_busy, // Calibration in progress
  output logic wd_event, // Limit crossed pulse
  output logic [15:0] res_data, // Oldest result
  output logic res_valid, // Result present
  input wire logic res_ready, // Host takes result
  output logic [5:0] fifo_count, // Results held
  output logic fifo_int // Fill interrupt level
);
  localparam int CW = $clog2(FIFO_DEPTH+1);
  initial begin
    if (FIFO_DEPTH < 32) $error("FIFO must hold at least 32 results");
    if (CW > 6) $error("FIFO depth exceeds count port");
  end

  // Bus pin synchroniser; stage one feeds stage two only
  logic [25:0] pin_s1_reg;
  logic [25:0] pin_s2_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 26'h3800000;
      pin_s2_reg <= 26'h3800000;
    end else begin
      pin_s1_reg <= {cs_n, rd_n, wr_n, ale, addr, bus_width_select, data_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic ale_s;
  logic [4:0] addr_s;
  logic bws_s;
  logic [15:0] din_s;
  assign cs_s = !pin_s2_reg[25];
  assign rd_s = !pin_s2_reg[24];
  assign wr_s = !pin_s2_reg[23];
  assign ale_s = pin_s2_reg[22];
  assign addr_s = pin_s2_reg[21:17];
  assign bws_s = pin_s2_reg[16];
  assign din_s = pin_s2_reg[15:0];

  // Address and select follow the pins while ALE is high, held after
  logic [4:0] addr_reg;
  logic csl_reg;
  logic wr_d_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= '0;
      csl_reg <= 1'b0;
      wr_d_reg <= 1'b0;
    end else begin
      if (ale_s) begin
        addr_reg <= addr_s;
        csl_reg <= cs_s;
      end
      wr_d_reg <= wr_s;
    end
  end

  // Both widths share the index A3..A1; A0 is the byte on a narrow bus
  logic hit;
  logic [2:0] idx;
  logic wr_take;
  assign hit = csl_reg && cs_s && !addr_reg[4];
  assign idx = addr_reg[3:1];
  assign wr_take = hit && wr_d_reg && !wr_s;

  logic [47:0] imem_reg [8];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        imem_reg[i] <= '0;
      end
    end else if (wr_take && cfg_ram_pointer != 2'h3) begin
      if (!bws_s) begin
        imem_reg[idx][cfg_ram_pointer*16 +: 16] <= din_s;
      end else begin
        imem_reg[idx][cfg_ram_pointer*16 + addr_reg[0]*8 +: 8] <=
          din_s[7:0];
      end
    end
  end

  // Read data from flops; upper lane released on a narrow bus
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe <= '0;
    end else if (hit && rd_s && cfg_ram_pointer != 2'h3) begin
      if (bws_s) begin
        data_out <= {8'h00,
          imem_reg[idx][cfg_ram_pointer*16 + addr_reg[0]*8 +: 8]};
        data_oe <= 16'h00FF;
      end else begin
        data_out <= imem_reg[idx][cfg_ram_pointer*16 +: 16];
        data_oe <= 16'hFFFF;
      end
    end else begin
      data_oe <= '0;
    end
  end

  // Sequencer and calibration engine
  adcsc_pkg::adcsc_state_t state_reg;
  logic [2:0] pc_reg;
  logic first_reg;
  logic halted_reg;
  logic [7:0] cnt_reg;
  logic [47:0] ins_reg;
  logic phase_reg;
  logic [12:0] raw_reg;
  logic push;
  logic push_ready;
  logic cal_full_reg;
  logic [3:0] rom_idx_reg;
  logic [2:0] rep_reg;
  logic signed [15:0] acc_reg;
  logic signed [7:0] off_coef_reg;
  logic signed [7:0] lin_coef_reg [`ADCSC_LIN_COEFS];

  function automatic logic [7:0] cal_rom(input logic [3:0] i);
    if (i == 4'h0) begin
      return `ADCSC_ROM_OFFSET;
    end else if (i <= 4'd13) begin
      return {`ADCSC_ROM_CAP, 4'(i - 4'h1)};
    end
    return 8'h00;
  endfunction

  logic [47:0] ins_now;
  logic [7:0] acq_cyc;
  logic short_conv;
  logic last_ins;
  assign ins_now = imem_reg[pc_reg];
  assign acq_cyc = 8'(`ADCSC_ACQ_MIN_CYC + `ADCSC_ACQ_STEP_CYC *
    ins_reg[`ADCSC_I_ACQ_LSB +: 4]);
  assign short_conv = ins_reg[`ADCSC_I_RES8] || ins_reg[`ADCSC_I_WDOG];
  assign last_ins = ins_reg[`ADCSC_I_LOOP] || pc_reg == 3'h7;

  // Background correction of the raw result
  logic signed [15:0] corr;
  logic signed [8:0] val8;
  logic signed [8:0] lim;
  logic wd_hit;
  always_comb begin
    val8 = 9'(signed'(raw_reg[12:4]) - off_coef_reg);
    corr = 16'(signed'(raw_reg)) - 16'(off_coef_reg);
    for (int b = 0; b < `ADCSC_LIN_COEFS; b++) begin
      if (raw_reg[b]) begin
        corr = corr - 16'(lin_coef_reg[b]);
      end
    end
    if (ins_reg[`ADCSC_I_RES8]) begin
      corr = 16'(val8);
    end
    lim = phase_reg ? {ins_reg[32+`ADCSC_L_SIGN], ins_reg[39:32]} :
      {ins_reg[16+`ADCSC_L_SIGN], ins_reg[23:16]};
    if (phase_reg ? ins_reg[32+`ADCSC_L_DIR] : ins_reg[16+`ADCSC_L_DIR]) begin
      wd_hit = val8 > lim;
    end else begin
      wd_hit = val8 < lim;
    end
  end

  assign push = state_reg == adcsc_pkg::ST_STORE &&
    !ins_reg[`ADCSC_I_WDOG];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= adcsc_pkg::ST_IDLE;
      pc_reg <= '0;
      first_reg <= 1'b1;
      halted_reg <= 1'b0;
      cnt_reg <= '0;
      ins_reg <= '0;
      phase_reg <= 1'b0;
      raw_reg <= '0;
      pause_event <= 1'b0;
      sar_start <= 1'b0;
      wd_event <= 1'b0;
      cal_full_reg <= 1'b0;
      rom_idx_reg <= '0;
      rep_reg <= '0;
      acc_reg <= '0;
      off_coef_reg <= '0;
      for (int k = 0; k < `ADCSC_LIN_COEFS; k++) begin
        lin_coef_reg[k] <= '0;
      end
    end else begin
      pause_event <= 1'b0;
      sar_start <= 1'b0;
      wd_event <= 1'b0;
      if (!cfg_start) begin
        halted_reg <= 1'b0;
      end
      if (cfg_soft_reset) begin
        state_reg <= adcsc_pkg::ST_IDLE;
        pc_reg <= '0;
        first_reg <= 1'b1;
        halted_reg <= 1'b0;
      end else begin
        case (state_reg)
          adcsc_pkg::ST_IDLE: begin
            if (cal_offset_req || cal_full_req) begin
              cal_full_reg <= cal_full_req;
              rom_idx_reg <= '0;
              rep_reg <= '0;
              acc_reg <= '0;
              state_reg <= adcsc_pkg::ST_CAL_MEAS;
            end else if (cfg_start && !halted_reg) begin
              state_reg <= adcsc_pkg::ST_FETCH;
            end
          end
          adcsc_pkg::ST_FETCH: begin
            ins_reg <= ins_now;
            if (ins_now[`ADCSC_I_PAUSE] && !first_reg) begin
              halted_reg <= 1'b1;
              pause_event <= 1'b1;
              state_reg <= adcsc_pkg::ST_IDLE;
            end else begin
              first_reg <= 1'b0;
              phase_reg <= 1'b0;
              cnt_reg <= 8'(`ADCSC_ACQ_MIN_CYC + `ADCSC_ACQ_STEP_CYC *
                ins_now[`ADCSC_I_ACQ_LSB +: 4]);
              state_reg <= adcsc_pkg::ST_ACQ;
            end
          end
          adcsc_pkg::ST_ACQ: begin
            if (cnt_reg == 8'h01) begin
              sar_start <= 1'b1;
              cnt_reg <= short_conv ? 8'(`ADCSC_CONV8_CYC) :
                8'(`ADCSC_CONV12_CYC);
              state_reg <= adcsc_pkg::ST_CONV;
            end else begin
              cnt_reg <= cnt_reg - 8'h01;
            end
          end
          adcsc_pkg::ST_CONV: begin
            if (cnt_reg == 8'h01) begin
              raw_reg <= adc_raw;
              state_reg <= adcsc_pkg::ST_STORE;
            end else begin
              cnt_reg <= cnt_reg - 8'h01;
            end
          end
          adcsc_pkg::ST_STORE: begin
            if (ins_reg[`ADCSC_I_WDOG] && !phase_reg) begin
              wd_event <= wd_hit;
              phase_reg <= 1'b1;
              sar_start <= 1'b1;
              cnt_reg <= 8'(`ADCSC_CONV8_CYC);
              state_reg <= adcsc_pkg::ST_CONV;
            end else if (!push || push_ready) begin
              wd_event <= ins_reg[`ADCSC_I_WDOG] && wd_hit;
              pc_reg <= last_ins ? 3'h0 : pc_reg + 3'h1;
              state_reg <= cfg_start ? adcsc_pkg::ST_FETCH :
                adcsc_pkg::ST_IDLE;
            end
          end
          adcsc_pkg::ST_CAL_MEAS: begin
            sar_start <= 1'b1;
            cnt_reg <= 8'(`ADCSC_CONV12_CYC);
            state_reg <= adcsc_pkg::ST_CAL_WAIT;
          end
          adcsc_pkg::ST_CAL_WAIT: begin
            if (cnt_reg != 8'h01) begin
              cnt_reg <= cnt_reg - 8'h01;
            end else if (cal_full_reg &&
                rep_reg != 3'(`ADCSC_CAL_REPS - 1)) begin
              acc_reg <= acc_reg + 16'(signed'(adc_raw));
              rep_reg <= rep_reg + 3'h1;
              state_reg <= adcsc_pkg::ST_CAL_MEAS;
            end else begin
              rep_reg <= '0;
              acc_reg <= '0;
              if (rom_idx_reg == 4'h0) begin
                off_coef_reg <= cal_full_reg ?
                  8'((acc_reg + 16'(signed'(adc_raw))) >>> 3) :
                  8'(signed'(adc_raw));
              end else begin
                lin_coef_reg[rom_idx_reg - 4'h1] <=
                  8'((acc_reg + 16'(signed'(adc_raw))) >>> 3);
              end
              if (!cal_full_reg || cal_rom(rom_idx_reg + 4'h1) == 8'h00) begin
                state_reg <= adcsc_pkg::ST_IDLE;
              end else begin
                rom_idx_reg <= rom_idx_reg + 4'h1;
                state_reg <= adcsc_pkg::ST_CAL_MEAS;
              end
            end
          end
          default: begin
            state_reg <= adcsc_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Analog routing held in flops so the core sees clean levels
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mux_pos <= '0;
      mux_neg <= '0;
      mux_diag <= 1'b0;
      sar_res8 <= 1'b0;
      cal_pattern <= '0;
    end else begin
      mux_pos <= ins_reg[`ADCSC_I_POS_LSB +: 3];
      mux_neg <= ins_reg[`ADCSC_I_NEG_LSB +: 3];
      mux_diag <= cfg_diag;
      sar_res8 <= short_conv;
      cal_pattern <= cal_busy ? cal_rom(rom_idx_reg) : 8'h00;
    end
  end

  assign seq_running = state_reg != adcsc_pkg::ST_IDLE && !cal_busy;
  assign cal_busy = state_reg == adcsc_pkg::ST_CAL_MEAS ||
    state_reg == adcsc_pkg::ST_CAL_WAIT;
  assign sh_acquire = state_reg == adcsc_pkg::ST_ACQ;

  // Full FIFO stalls the store step; no result is dropped except by a soft reset
  logic [CW-1:0] fcount;
  adcsc_fifo #(.W(16), .D(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_data(corr),
    .in_valid(push),
    .in_ready(push_ready),
    .out_data(res_data),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .count(fcount)
  );
  assign fifo_count = 6'(fcount);

  // Set wins over clear so a fill in the clearing cycle is kept
  logic fill_hit;
  assign fill_hit = push && push_ready &&
    (fcount + CW'(1) == CW'(fifo_int_count) ||
     fcount + CW'(1) == CW'(FIFO_DEPTH));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_int <= 1'b0;
    end else if (fill_hit) begin
      fifo_int <= 1'b1;
    end else if (fifo_int_clear) begin
      fifo_int <= 1'b0;
    end
  end

  // Helper counters watched by the checks below
  logic [7:0] acq_len_q;
  logic [7:0] conv_len_q;
  logic [7:0] cal_starts_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acq_len_q <= '0;
      conv_len_q <= '0;
      cal_starts_q <= '0;
    end else begin
      acq_len_q <= sh_acquire ? acq_len_q + 8'h01 : 8'h00;
      conv_len_q <= sar_start ? 8'h01 : conv_len_q + 8'h01;
      if (state_reg == adcsc_pkg::ST_IDLE) begin
        cal_starts_q <= '0;
      end else if (cal_busy && sar_start) begin
        cal_starts_q <= cal_starts_q + 8'h01;
      end
    end
  end

  property p_upper_release;
    @(posedge mclk) disable iff (!rst_n)
    bws_s && $stable(bws_s) |=> data_oe[15:8] == 8'h00;
  endproperty
  a_upper_release: assert property (p_upper_release)
    else $error("Upper data lanes driven on narrow bus");

  property p_run_status;
    @(posedge mclk) disable iff (!rst_n)
    state_reg == adcsc_pkg::ST_IDLE && cfg_start && !halted_reg &&
    !cal_offset_req && !cal_full_req && !cfg_soft_reset |=> seq_running;
  endproperty
  a_run_status: assert property (p_run_status)
    else $error("Running status not shown after start");

  property p_acq_window;
    @(posedge mclk) disable iff (!rst_n)
    $fell(sh_acquire) && state_reg == adcsc_pkg::ST_CONV |->
      acq_len_q == acq_cyc &&
      acq_len_q >= 8'(`ADCSC_ACQ_MIN_CYC) &&
      acq_len_q <= 8'(`ADCSC_ACQ_MAX_CYC);
  endproperty
  a_acq_window: assert property (p_acq_window)
    else $error("Acquisition time out of range");

  property p_short_conv;
    @(posedge mclk) disable iff (!rst_n)
    state_reg == adcsc_pkg::ST_STORE && $changed(state_reg) && sar_res8 |->
      2 * conv_len_q < 8'(`ADCSC_CONV12_CYC) + 8'h02;
  endproperty
  a_short_conv: assert property (p_short_conv)
    else $error("Short conversion not under half the long one");

  property p_fifo_full;
    @(posedge mclk) disable iff (!rst_n)
    push && !push_ready && !cfg_soft_reset |=> push;
  endproperty
  a_fifo_full: assert property (p_fifo_full)
    else $error("Result dropped while FIFO full");

  property p_fill_int;
    @(posedge mclk) disable iff (!rst_n)
    fill_hit |=> fifo_int;
  endproperty
  a_fill_int: assert property (p_fill_int)
    else $error("Fill interrupt not raised");

  property p_diag_route;
    @(posedge mclk) disable iff (!rst_n)
    cfg_diag ##1 cfg_diag |-> mux_diag;
  endproperty
  a_diag_route: assert property (p_diag_route)
    else $error("Diagnostic routing not applied");

  property p_cal_offset_once;
    @(posedge mclk) disable iff (!rst_n)
    $fell(cal_busy) && !cal_full_reg && !$past(cfg_soft_reset) |->
      cal_starts_q == 8'h01;
  endproperty
  a_cal_offset_once: assert property (p_cal_offset_once)
    else $error("Offset calibration not a single measurement");

  property p_cal_full_count;
    @(posedge mclk) disable iff (!rst_n)
    $fell(cal_busy) && cal_full_reg && !$past(cfg_soft_reset) |->
      cal_starts_q == 8'd112;
  endproperty
  a_cal_full_count: assert property (p_cal_full_count)
    else $error("Full calibration measurement count wrong");
endmodule // adcsc_top
`default_nettype wire

// ==== tb/adcsc_host_model.sv ====
// Host side of the parallel bus: plain pin-level write and read cycles.
// Assumes ale held high and the device on the same mclk.
`timescale 1ns/1ns
`default_nettype none
module adcsc_host_model (
  input wire logic mclk, // Clock
  output logic cs_n, // Chip select
  output logic rd_n, // Read strobe
  output logic wr_n, // Write strobe
  output logic [4:0] addr, // Address
  output logic [15:0] data_in, // Data to device
  input wire logic [15:0] data_out, // Data from device
  input wire logic [15:0] data_oe // Device drive enables
);
  logic [15:0] oe_seen;
  initial begin
    {cs_n, rd_n, wr_n} = 3'h7;
    addr = 5'h00;
    data_in = 16'h0000;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // Strobes held 4 cycles; select and data kept until the pins are synced
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    addr = a;
    data_in = d;
    {cs_n, wr_n} = 2'h0;
    step(4);
    wr_n = 1'b1;
    step(4);
    cs_n = 1'b1;
    data_in = ~d; // Released lines show the inverse
    step(3);
  endtask
  task automatic read(input logic [4:0] a, output logic [15:0] d);
    addr = a;
    {cs_n, rd_n} = 2'h0;
    step(6);
    d = data_out & data_oe; // Undriven lines read as 0
    oe_seen = data_oe;
    {cs_n, rd_n} = 2'h3;
    step(5);
  endtask
endmodule // adcsc_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench: host model on the bus, queue model of results.
// Assumes adcsc_top with its default FIFO depth.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk, rst_n, cs_n, rd_n, wr_n, bus_width_select, cfg_start;
  logic cfg_soft_reset, cfg_diag, cal_offset_req, fifo_int_clear, res_ready;
  logic seq_running, mux_diag, sar_start, cal_busy, res_valid, fifo_int;
  logic cal_full_req, sar_res8;
  logic [7:0] cal_pattern;
  logic [4:0] addr;
  logic [15:0] data_in, data_out, data_oe, res_data, rv;
  logic [15:0] w [8];
  logic [15:0] q [$];
  logic [1:0] cfg_ram_pointer;
  logic [5:0] fifo_int_count, fifo_count;
  logic [12:0] adc_raw;
  logic [2:0] mux_pos;
  logic [31:0] lfsr = 32'h5651C7C2;
  int fails, comparisons, k, starts, v;
  adcsc_host_model u_host (.mclk, .cs_n, .rd_n, .wr_n, .addr, .data_in,
    .data_out, .data_oe);
  adcsc_top u_dut (.mclk, .rst_n, .cs_n, .rd_n, .wr_n, .ale(1'b1), .addr,
    .bus_width_select, .data_in, .data_out, .data_oe, .cfg_start,
    .cfg_soft_reset, .cfg_ram_pointer, .cfg_diag, .cal_offset_req,
    .cal_full_req, .fifo_int_count, .fifo_int_clear, .seq_running,
    .pause_event(), .mux_pos, .mux_neg(), .mux_diag, .sh_acquire(),
    .sar_start, .sar_res8, .cal_pattern, .adc_raw, .cal_busy,
    .wd_event(), .res_data, .res_valid, .res_ready, .fifo_count, .fifo_int);
  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wait_sig(ref logic s, input logic val);
    k = 0;
    while (s !== val && k < 6000) begin
      u_host.step(1);
      k++;
    end
    check({15'h0000, s}, {15'h0000, val});
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    u_host.step(1);
    s = 1'b0;
  endtask
  // New raw value per conversion; calibration keeps raw at 5
  always @(posedge mclk) begin
    if (sar_start === 1'b1) begin
      starts++;
      if (seq_running === 1'b1) begin
        #2;
        adc_raw = 13'(next_rand());
        // Both calibrations leave offset at 5; the full one also sets every linearity term to 5
        v = (sar_res8 === 1'b1) ? int'($signed(adc_raw[12:4] - 9'h005)) :
          $signed(adc_raw) - 5 * (1 + $countones(adc_raw));
        q.push_back(v[15:0]);
      end
    end
  end
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #(20000 * 50);
    fails++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    {bus_width_select, cfg_start, cfg_soft_reset, cfg_diag} = 4'h0;
    {cal_offset_req, cal_full_req, fifo_int_clear, res_ready} = 4'h0;
    cfg_ram_pointer = 2'h0;
    fifo_int_count = 6'h04;
    adc_raw = 13'h0005;
    u_host.step(4);
    rst_n = 1'b1;
    check(data_oe, 16'h0000);
    u_host.step(3);
    pulse(cal_offset_req);
    wait_sig(cal_busy, 1'b1);
    u_host.step(1);
    check({8'h00, cal_pattern}, 16'h0080);
    wait_sig(cal_busy, 1'b0);
    check(starts[15:0], 16'h0001);
    pulse(cal_full_req);
    wait_sig(cal_busy, 1'b1);
    wait_sig(cal_busy, 1'b0);
    check(starts[15:0], 16'h0071);
    // Sequencer idle after reset, so memory may be touched
    for (int i = 7; i >= 0; i--) begin
      // Long conversion on 3, then short on 4 with loop back
      w[i] = (i == 0) ? 16'h000C : (i == 1) ? 16'h0411 : 16'(next_rand());
      u_host.write({1'b0, i[2:0], 1'b0}, w[i]);
    end
    for (int i = 0; i < 8; i++) begin
      u_host.read({1'b0, i[2:0], 1'b0}, rv);
      check(rv, w[i]);
    end
    cfg_ram_pointer = 2'h1;
    u_host.write(5'h04, 16'h0255);
    u_host.read(5'h04, rv);
    check(rv, 16'h0255);
    cfg_ram_pointer = 2'h0;
    u_host.read(5'h04, rv);
    check(rv, w[2]);
    bus_width_select = 1'b1;
    u_host.write(5'h0D, 16'h00A5);
    u_host.read(5'h0D, rv);
    check(rv, 16'h00A5);
    check(u_host.oe_seen, 16'h00FF);
    bus_width_select = 1'b0;
    u_host.read(5'h0C, rv);
    check(rv, {8'hA5, w[6][7:0]});
    u_host.read(5'h10, rv);
    check(u_host.oe_seen, 16'h0000);
    pulse(cfg_soft_reset);
    cfg_diag = 1'b1;
    u_host.step(2);
    check({15'h0000, mux_diag}, 16'h0001);
    cfg_diag = 1'b0;
    cfg_start = 1'b1;
    wait_sig(seq_running, 1'b1);
    wait_sig(sar_start, 1'b1);
    check({13'h0000, mux_pos}, 16'h0003);
    wait_sig(fifo_int, 1'b1);
    check({10'h000, fifo_count}, 16'h0004);
    // Long enough to fill; the next store then waits for room
    u_host.step(2500);
    check({10'h000, fifo_count}, 16'h0020);
    check(16'(q.size()), 16'h0021);
    cfg_start = 1'b0;
    res_ready = 1'b1;
    while (res_valid === 1'b1 && q.size() > 0) begin
      check(res_data, q.pop_front());
      u_host.step(1);
    end
    res_ready = 1'b0;
    check({15'h0000, res_valid}, 16'h0000);
    check(16'(q.size()), 16'h0000);
    wait_sig(seq_running, 1'b0);
    pulse(fifo_int_clear);
    check({15'h0000, fifo_int}, 16'h0000);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
